/* File: core/bcc_top.sv */
// Purpose: switch sequencing and setting selection for three buck converters
// Assumes: comparator inputs come from analog logic on the core clock
// Notes: settings are plain ports except converter one's, held in a local register; host-side register access lives elsewhere
//
// Overview of operation
// RL1 - pwm at about 2.25MHz under load, pfm automatically at light load
// RL2 - each pwm cycle starts by turning the high-side switch on
// RL3 - high-side switch turns off when the pwm comparator trips
// RL4 - high-side switch also turns off on current limit, always
// RL5 - dead time with both off before the low-side switch turns on
// RL6 - next clock edge turns low side off, then high side on
// RL7 - all converters locked to one clock, converter one is master
// RL8 - converter two cycle starts half a period after converter one
// RL9 - converter three cycle starts together with converter one
// RL10 - converter one target comes from its host-writable setting register
// RL11 - setting option selects external divider feedback for converter one
// RL12 - converter two select pin picks its low or high setting
// RL13 - converter three select pin picks its low or high setting
// RL14 - host changes levels by toggling select pins or rewriting settings
// RL15 - tracking bit makes second linear regulator follow converter three level
// RL16 - power save enabled after reset, disable per converter forces pwm
// RL17 - pwm to pfm once low-side current falls to zero in a cycle
// RL18 - select pins synchronized to the clock before use
// RL19 - high-side and low-side drives never on together
`timescale 1ns/100ps
module bcc_top (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire bcc_pkg::bcc_sense_type [2:0] i_sense,
    input wire logic [2:0] i_psave_dis,
    input wire logic i_buck1_wr,
    input wire logic [bcc_pkg::VSET_W-1:0] i_buck1_wdata,
    input wire logic i_buck1_ext_wdata,
    input wire logic [bcc_pkg::VSET_W-1:0] i_buck2_low_setting,
    input wire logic [bcc_pkg::VSET_W-1:0] i_buck2_high_setting,
    input wire logic [bcc_pkg::VSET_W-1:0] i_buck3_low_setting,
    input wire logic [bcc_pkg::VSET_W-1:0] i_buck3_high_setting,
    input wire logic i_buck2_level_select_pin,
    input wire logic i_buck3_level_select_pin,
    input wire logic [bcc_pkg::VSET_W-1:0] i_linreg2_setting,
    input wire logic i_linreg2_follow_buck3,
    output bcc_pkg::bcc_drive_type [2:0] o_drive,
    output logic [bcc_pkg::VSET_W-1:0] o_buck1_target,
    output logic o_buck1_ext_fb,
    output logic [bcc_pkg::VSET_W-1:0] o_buck2_target,
    output logic [bcc_pkg::VSET_W-1:0] o_buck3_target,
    output logic [bcc_pkg::VSET_W-1:0] o_linreg2_target
);
    import bcc_pkg::*;

    // =====================================================
    // master timebase
    logic [CNT_W-1:0] cnt_r;
    logic [2:0] cyc_start;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= '0;
        end else if (cnt_r == CNT_W'(PERIOD_CYC - 1)) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // converter one is master; two is offset half a period, three in phase
    assign cyc_start[0] = (cnt_r == '0); // see RL7
    assign cyc_start[1] = (cnt_r == CNT_W'(HALF_CYC)); // see RL8
    assign cyc_start[2] = (cnt_r == '0); // see RL9

    // one core cycle before each start, so the low side is off before the high side
    // comes on; costs one core cycle of low-side conduction per period
    logic [2:0] pre_start;
    assign pre_start[0] = (cnt_r == CNT_W'(PERIOD_CYC - 1)); // see RL6
    assign pre_start[1] = (cnt_r == CNT_W'(HALF_CYC - 1)); // see RL6
    assign pre_start[2] = (cnt_r == CNT_W'(PERIOD_CYC - 1)); // see RL6

    // =====================================================
    // select pin synchronizers
    logic [1:0] sel_s1_r;
    logic [1:0] sel_s2_r;
    logic [1:0] sel_r;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sel_s1_r <= 2'h0;
            sel_s2_r <= 2'h0;
        end else begin
            sel_s1_r <= {i_buck3_level_select_pin, i_buck2_level_select_pin}; // see RL18
            sel_s2_r <= sel_s1_r;
        end
    end

    // applied only at converter one's cycle boundary, so a toggle lands cleanly
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sel_r <= 2'h0;
        end else if (cyc_start[0]) begin
            sel_r <= sel_s2_r; // see RL18
        end
    end

    // =====================================================
    // setting selection
    logic [VSET_W-1:0] buck1_set_r;
    logic buck1_ext_r;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            buck1_set_r <= BUCK1_RST;
            buck1_ext_r <= BUCK1_EXT_RST;
        end else if (i_buck1_wr) begin
            buck1_set_r <= i_buck1_wdata; // see RL10
            buck1_ext_r <= i_buck1_ext_wdata; // see RL11
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_buck1_target <= BUCK1_RST;
            o_buck1_ext_fb <= BUCK1_EXT_RST;
            o_buck2_target <= '0;
            o_buck3_target <= '0;
            o_linreg2_target <= '0;
        end else begin
            o_buck1_target <= buck1_set_r; // see RL10
            o_buck1_ext_fb <= buck1_ext_r; // see RL11
            o_buck2_target <= sel_r[0] ? i_buck2_high_setting
                                       : i_buck2_low_setting; // see RL12
            o_buck3_target <= sel_r[1] ? i_buck3_high_setting
                                       : i_buck3_low_setting; // see RL13
            // tracking follows the level selected, one cycle behind it
            o_linreg2_target <= i_linreg2_follow_buck3 ? o_buck3_target
                                                       : i_linreg2_setting; // see RL15
        end
    end

    // =====================================================
    // per-converter switch sequencer
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_conv
            bcc_phase_type ph_r;
            logic [1:0] dead_r;
            logic pfm_r;
            logic psave_en;

            // power save enabled unless the host disables it
            assign psave_en = PSAVE_EN_RST[g] & ~i_psave_dis[g]; // see RL16

            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    pfm_r <= 1'b0;
                end else if (!psave_en) begin
                    pfm_r <= 1'b0; // see RL16
                end else if (ph_r == PH_LOW && i_sense[g].izero) begin
                    pfm_r <= 1'b1; // see RL17
                end else if (i_sense[g].pfm_low) begin
                    pfm_r <= 1'b0; // see RL1
                end
            end

            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    ph_r <= PH_IDLE;
                    dead_r <= 2'h0;
                end else begin
                    unique case (ph_r)
                        PH_IDLE: begin
                            // pfm skips cycles until output sags
                            if (cyc_start[g] && (!pfm_r || i_sense[g].pfm_low)) begin
                                ph_r <= PH_HIGH; // see RL2
                            end
                        end
                        PH_HIGH: begin
                            if (i_sense[g].pwm_trip || i_sense[g].ilim_trip) begin
                                ph_r <= PH_DEAD; // see RL3 see RL4
                                dead_r <= 2'(DEAD_CYC - 1);
                            end
                        end
                        PH_DEAD: begin
                            if (dead_r == 2'h0) begin
                                ph_r <= PH_LOW; // see RL5
                            end else begin
                                dead_r <= dead_r - 1'b1;
                            end
                        end
                        PH_LOW: begin
                            // released just before the start, so every pwm period gets its pulse
                            if (pre_start[g] || (pfm_r && i_sense[g].izero)) begin
                                ph_r <= PH_IDLE; // see RL6
                            end
                        end
                    endcase
                end
            end

            // no high-side turn-on straight from low side, so never overlapped
            assign o_drive[g].high_on = (ph_r == PH_HIGH); // see RL19
            assign o_drive[g].low_on = (ph_r == PH_LOW); // see RL19
            assign o_drive[g].pfm_mode = pfm_r;

            no_overlap_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL19
                !(o_drive[g].high_on && o_drive[g].low_on))
                else $error("both switches on");

            sequence s_off;
                o_drive[g].high_on ##1 !o_drive[g].high_on;
            endsequence
            dead_gap_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL5
                s_off |-> !o_drive[g].low_on [*2])
                else $error("low side without dead time");

            sequence s_gap;
                (!o_drive[g].high_on && !o_drive[g].low_on) [*2];
            endsequence
            dead_order_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL5
                s_off |-> s_gap ##1 o_drive[g].low_on)
                else $error("low side not on after dead time");

            trip_off_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL4
                (o_drive[g].high_on && i_sense[g].ilim_trip) |=> !o_drive[g].high_on)
                else $error("current limit ignored");

            pwm_off_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL3
                (o_drive[g].high_on && i_sense[g].pwm_trip) |=> !o_drive[g].high_on)
                else $error("pwm trip ignored");

            start_high_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL2
                $rose(o_drive[g].high_on) |-> $past(cyc_start[g]))
                else $error("high side on off cycle start");

            every_cycle_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL2
                (cyc_start[g] && !pfm_r && (ph_r == PH_IDLE || ph_r == PH_LOW))
                |=> o_drive[g].high_on)
                else $error("pwm cycle started without high side");

            low_release_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL6
                (o_drive[g].low_on && pre_start[g]) |=> !o_drive[g].low_on)
                else $error("low side held into next cycle");

            forced_pwm_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL16
                i_psave_dis[g] |=> !o_drive[g].pfm_mode)
                else $error("pfm while power save disabled");

            pfm_enter_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL17
                (psave_en && o_drive[g].low_on && i_sense[g].izero) |=> o_drive[g].pfm_mode)
                else $error("pfm not entered at zero current");
        end
    endgenerate

    localparam int HALF_DLY = HALF_CYC;
    phase_half_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL8
        cyc_start[0] |-> ##HALF_DLY cyc_start[1])
        else $error("converter two phase wrong");

    in_phase_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL9
        cyc_start[0] == cyc_start[2])
        else $error("converter three out of phase");

    conv2_start_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL8
        $rose(o_drive[1].high_on) |-> $past(cnt_r) == CNT_W'(HALF_CYC))
        else $error("converter two started off its phase");

    conv3_start_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL9
        $rose(o_drive[2].high_on) |-> $past(cnt_r) == '0)
        else $error("converter three started off its phase");

    // =====================================================
    // setting checks
    sel_target_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL12
        sel_r[0] |=> o_buck2_target == $past(i_buck2_high_setting))
        else $error("wrong converter two setting");

    sel_low_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL12
        !sel_r[0] |=> o_buck2_target == $past(i_buck2_low_setting))
        else $error("wrong converter two low setting");

    buck3_high_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL13
        sel_r[1] |=> o_buck3_target == $past(i_buck3_high_setting))
        else $error("wrong converter three high setting");

    buck3_low_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL13
        !sel_r[1] |=> o_buck3_target == $past(i_buck3_low_setting))
        else $error("wrong converter three low setting");

    track_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL15
        i_linreg2_follow_buck3 |=> o_linreg2_target == $past(o_buck3_target))
        else $error("tracking not followed");

    own_level_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL15
        !i_linreg2_follow_buck3 |=> o_linreg2_target == $past(i_linreg2_setting))
        else $error("linear regulator setting not used");

    buck1_load_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL10
        i_buck1_wr |=> buck1_set_r == $past(i_buck1_wdata))
        else $error("converter one setting not loaded");

    ext_fb_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL11
        i_buck1_wr |=> ##1 o_buck1_ext_fb == $past(i_buck1_ext_wdata, 2))
        else $error("external feedback option not applied");

    sel_sync_a: assert property (@(posedge i_clock) disable iff (i_rst) // see RL18
        cyc_start[0] |=> sel_r == $past(sel_s2_r))
        else $error("select pins not taken at cycle start");
endmodule

/* File: core/bcc_pkg.sv */
// Purpose: shared constants and carriers for the buck converter control block
// Assumes: 100 MHz core clock, 6-bit voltage codes
// Notes: switching period rounded to whole core cycles
package bcc_pkg;
    // =====================================================
    // timing
    localparam int CLK_FREQ_KHZ = 100000;
    localparam int SW_FREQ_KHZ = 2250;
    // one switching period, rounded down to whole cycles
    localparam int PERIOD_CYC = CLK_FREQ_KHZ / SW_FREQ_KHZ;
    localparam int HALF_CYC = PERIOD_CYC / 2;
    localparam int DEAD_TIME_NS = 20;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 6;
    localparam int VSET_W = 6;
    // =====================================================
    // reset values
    localparam logic [VSET_W-1:0] BUCK1_RST = 6'h00;
    localparam logic BUCK1_EXT_RST = 1'b0;
    localparam logic [2:0] PSAVE_EN_RST = 3'h7;
    // =====================================================
    // types
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_HIGH,
        PH_DEAD,
        PH_LOW
    } bcc_phase_type;
    typedef struct packed {
        logic pwm_trip;
        logic ilim_trip;
        logic izero;
        logic pfm_low;
    } bcc_sense_type;
    typedef struct packed {
        logic high_on;
        logic low_on;
        logic pfm_mode;
    } bcc_drive_type;
endpackage

/* File: verif/bcc_stage_model.sv */
// Purpose: power stage stand-in giving comparator levels for one converter
// Assumes: comparators settle within one core cycle
// Notes: trip moment set by i_on_len, light load by i_light
`timescale 1ns/100ps
module bcc_stage_model (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire bcc_pkg::bcc_drive_type i_drive,
    input wire logic [5:0] i_on_len,
    input wire logic i_lim,
    input wire logic i_light,
    output bcc_pkg::bcc_sense_type o_sense
);
    import bcc_pkg::*;
    logic [5:0] on_cnt_r;
    logic ramp_done;
    // =========================
    // inductor current ramp
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            on_cnt_r <= 6'h00;
        end else begin
            on_cnt_r <= i_drive.high_on ? on_cnt_r + 6'h01 : 6'h00;
        end
    end
    assign ramp_done = i_drive.high_on && (on_cnt_r >= i_on_len);
    // trip and zero-current comparators only fire while their switch conducts; pfm_low follows load alone
    assign o_sense.pwm_trip = ramp_done && !i_lim;
    assign o_sense.ilim_trip = ramp_done && i_lim;
    // no low threshold hit while lightly loaded, so pfm is kept
    assign o_sense.izero = i_light && i_drive.low_on;
    assign o_sense.pfm_low = !i_light;
endmodule

/* File: verif/bcc_top_tb.sv */
// Purpose: self-checking bench for bcc_top
// Assumes: one stage model per converter
// Notes: a monitor checks switch timing on every cycle
`timescale 1ns/100ps
module bcc_top_tb;
    import bcc_pkg::*;
    logic clock, rst, wr, ext, sel2, sel3, follow, b1x;
    logic [2:0] dis, pdis, lim, light;
    logic [VSET_W-1:0] wdata, lo2, hi2, lo3, hi3, ldo, b1, b2, b3, l2;
    logic [5:0] on_len [3];
    wire bcc_sense_type [2:0] sense;
    bcc_sense_type [2:0] psense;
    bcc_drive_type [2:0] drv, pdrv;
    int miscompares, n_compared, cyc, dcnt[3], npfm[3], nhigh[3];
    bcc_top u_bcc_top (.i_clock(clock), .i_rst(rst), .i_sense(sense), .i_psave_dis(dis),
        .i_buck1_wr(wr), .i_buck1_wdata(wdata), .i_buck1_ext_wdata(ext),
        .i_buck2_low_setting(lo2), .i_buck2_high_setting(hi2), .i_buck3_low_setting(lo3),
        .i_buck3_high_setting(hi3), .i_buck2_level_select_pin(sel2),
        .i_buck3_level_select_pin(sel3), .i_linreg2_setting(ldo),
        .i_linreg2_follow_buck3(follow), .o_drive(drv), .o_buck1_target(b1),
        .o_buck1_ext_fb(b1x), .o_buck2_target(b2), .o_buck3_target(b3), .o_linreg2_target(l2));
    for (genvar k = 0; k < 3; k++) begin : g_stage
        bcc_stage_model u_bcc_stage_model (.i_clock(clock), .i_rst(rst), .i_drive(drv[k]),
            .i_on_len(on_len[k]), .i_lim(lim[k]), .i_light(light[k]), .o_sense(sense[k]));
    end
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // =========================
    // expectations
    function automatic int phase(input int k);
        return (k == 1) ? HALF_CYC + 1 : 1;
    endfunction
    function automatic logic [5:0] pick(input logic s, input logic [5:0] lo, input logic [5:0] hi);
        return s ? hi : lo;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // =========================
    // cycle monitor, sees pre-edge values
    always @(posedge clock) begin
        if (rst) begin
            cyc = 0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                check("both drives", drv[k].high_on & drv[k].low_on, 0);
                if (pdrv[k].high_on && (psense[k].pwm_trip || psense[k].ilim_trip))
                    check("trip off", drv[k].high_on, 0);
                if (drv[k].high_on && !pdrv[k].high_on) begin
                    nhigh[k]++;
                    check("start phase", cyc % PERIOD_CYC, phase(k));
                end
                // low side is released one core cycle ahead of the next start
                if (pdrv[k].low_on && !drv[k].low_on && !psense[k].izero)
                    check("low end phase", (cyc + 1) % PERIOD_CYC, phase(k));
                if (drv[k].high_on) dcnt[k] = 0;
                else if (!drv[k].low_on) dcnt[k]++;
                if (drv[k].low_on && !pdrv[k].low_on)
                    check("dead cycles", dcnt[k], DEAD_CYC);
                if (pdis[k]) check("forced pwm", drv[k].pfm_mode, 0);
                npfm[k] += drv[k].pfm_mode;
            end
            cyc++;
        end
        pdrv = drv;
        psense = sense;
        pdis = dis;
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        conclude();
    end
    initial begin
        void'($urandom(67046));
        rst = 1'b1;
        {wr, ext, sel2, sel3, follow, dis, lim, light} = '0;
        {wdata, lo2, hi2, lo3, hi3, ldo} = '0;
        on_len = '{6'h0A, 6'h0A, 6'h0A};
        repeat (20) @(posedge clock);
        check("reset outputs", {b1x, b1, b2, b3, l2}, {BUCK1_EXT_RST, BUCK1_RST, 18'h0});
        rst <= 1'b0;
        // shortest and longest on time first, then random ones
        for (int r = 0; r < 6; r++) begin
            for (int k = 0; k < 3; k++) begin
                on_len[k] <= (r < 2) ? (r ? 6'h1E : 6'h01) : 6'($urandom_range(30, 1));
                lim[k] <= 1'($urandom);
            end
            repeat (3 * PERIOD_CYC) @(posedge clock);
        end
        // six rounds of three periods, one high-side pulse in each
        for (int k = 0; k < 3; k++)
            check("high per period", nhigh[k], 6 * 3);
        $display("test switching done");
        for (int r = 0; r < 2; r++) begin
            dis <= r ? 3'h2 : 3'h5;
            light <= 3'h7;
            npfm = '{0, 0, 0};
            repeat (4 * PERIOD_CYC) @(posedge clock);
            for (int k = 0; k < 3; k++)
                check("pfm entered", npfm[k] != 0, !dis[k]);
            light <= 3'h0;
            repeat (2 * PERIOD_CYC) @(posedge clock);
            for (int k = 0; k < 3; k++)
                check("pfm left", drv[k].pfm_mode, 0);
        end
        $display("test power save done");
        for (int r = 0; r < 8; r++) begin
            wdata <= 6'($urandom);
            ext <= 1'($urandom);
            {lo2, hi2, lo3, hi3, ldo} <= 30'($urandom);
            {follow, sel3, sel2} <= 3'(r);
            wr <= 1'b1;
            @(posedge clock);
            wr <= 1'b0;
            repeat (4) @(posedge clock);
            check("buck1 target", {b1x, b1}, {ext, wdata});
            repeat (50) @(posedge clock);
            check("buck2 target", b2, pick(sel2, lo2, hi2));
            check("buck3 target", b3, pick(sel3, lo3, hi3));
            check("linreg2 target", l2, follow ? pick(sel3, lo3, hi3) : ldo);
        end
        $display("test settings done");
        conclude();
    end
endmodule
